// ### dv/cct_pin_src.sv
// External pulse source model for the capture pin
`timescale 1ns/1ns
module cct_pin_src (
	// Clock used to time pin changes
	input wire logic clk,
	// Pin level toward the timer
	output logic capture_pin
);
	// Pin idles low until the bench asks for a level
	initial capture_pin = 1'b0;
	// Hold a level, changed just after a rising edge
	task automatic set_level(input logic lvl);
		@(posedge clk);
		capture_pin <= lvl;
	endtask
	// High pulse of n clk cycles, then back low
	task automatic pulse(input int n);
		set_level(1'b1);
		repeat (n) @(posedge clk);
		capture_pin <= 1'b0;
	endtask
endmodule

// ### dv/cct_timer_tb.sv
// Self-checking bench for the capture timer
`timescale 1ns/1ns
module cct_timer_tb;
	// Clock, reset and bus drive
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic watch_clk = 1'b0;
	// Design outputs
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic capture_pin;
	logic timer_irq_request;
	// Tallies and last read result
	int n_mismatch = 0;
	int checks_done = 0;
	logic [31:0] rdat;
	logic [31:0] base;
	logic rerr;

	// 40 ns period
	always #20 clk = ~clk;

	cct_timer DUT (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_pin(capture_pin), .watch_clk(watch_clk), .timer_irq_request(timer_irq_request));
	cct_pin_src SRC (.clk(clk), .capture_pin(capture_pin));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a wait that never ends
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Single compare for every kind of result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Given number of watch clock periods, six system clocks each
	task automatic wedges(input int n);
		repeat (n) begin
			watch_clk <= 1'b1;
			cyc(3);
			watch_clk <= 1'b0;
			cyc(3);
		end
	endtask
	// Four watch clock periods give one divided falling edge
	task automatic quad();
		wedges(4);
	endtask
	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog, far beyond the several hundred cycles the tests need
	initial begin
		cyc(20000);
		n_mismatch++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		cyc(12);
		rst <= 1'b0;
		rd_chk(cct_pkg::OFS_MODE, 32'h0);
		rd_chk(cct_pkg::OFS_STATUS, 32'h0);
		rd_chk(cct_pkg::OFS_RISE, 32'h0);
		rd_chk(8'h1c, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		$display("test reset done");
		// Stopped watch clock keeps the counter still between steps
		wr(cct_pkg::OFS_MODE, 32'h0f);
		apb(1'b0, cct_pkg::OFS_COUNTER, 32'h0);
		base = rdat;
		quad();
		rd_chk(cct_pkg::OFS_COUNTER, base + 1);
		quad();
		rd_chk(cct_pkg::OFS_COUNTER, base + 2);
		$display("test count done");
		SRC.set_level(1'b1);
		cyc(10);
		rd_chk(cct_pkg::OFS_STATUS, 32'h0);
		rd_chk(cct_pkg::OFS_COUNTER, base + 2);
		wr(cct_pkg::OFS_PORT_ONE, 32'h1);
		cyc(10);
		rd_chk(cct_pkg::OFS_STATUS, 32'h1);
		chk({31'h0, timer_irq_request}, 32'h1);
		rd_chk(cct_pkg::OFS_RISE, base + 2);
		rd_chk(cct_pkg::OFS_COUNTER, 32'h0);
		wr(cct_pkg::OFS_STATUS, 32'h1);
		rd_chk(cct_pkg::OFS_STATUS, 32'h0);
		$display("test select rise done");
		// Falling edge made by deselecting while the pin is high
		wr(cct_pkg::OFS_MODE, 32'h13);
		quad();
		wr(cct_pkg::OFS_PORT_ONE, 32'h0);
		cyc(10);
		rd_chk(cct_pkg::OFS_STATUS, 32'h1);
		chk({31'h0, timer_irq_request}, 32'h1);
		rd_chk(cct_pkg::OFS_FALL, 32'h1);
		rd_chk(cct_pkg::OFS_COUNTER, 32'h0);
		$display("test select fall done");
		// Short pulses must vanish in the five-tap filter
		SRC.set_level(1'b0);
		wr(cct_pkg::OFS_PORT_ONE, 32'h1);
		wr(cct_pkg::OFS_MODE, 32'h1f);
		quad();
		wr(cct_pkg::OFS_STATUS, 32'h1);
		SRC.pulse(3);
		cyc(10);
		rd_chk(cct_pkg::OFS_STATUS, 32'h0);
		SRC.pulse(8);
		cyc(10);
		rd_chk(cct_pkg::OFS_STATUS, 32'h1);
		rd_chk(cct_pkg::OFS_RISE, 32'h1);
		rd_chk(cct_pkg::OFS_COUNTER, 32'h0);
		$display("test filter done");
		// Reselect from a high watch level to a low sys/64 level
		wedges(2);
		wr(cct_pkg::OFS_MODE, 32'h00);
		apb(1'b0, cct_pkg::OFS_COUNTER, 32'h0);
		base = rdat;
		// Wait for a divider wrap, so the sys/64 level is known to stay low for a while
		do begin
			apb(1'b0, cct_pkg::OFS_COUNTER, 32'h0);
		end while (rdat == base);
		base = rdat;
		wr(cct_pkg::OFS_MODE, 32'h03);
		rd_chk(cct_pkg::OFS_COUNTER, base);
		wr(cct_pkg::OFS_MODE, 32'h00);
		rd_chk(cct_pkg::OFS_COUNTER, base + 1);
		$display("test reselect done");
		// Filter on, sampled by the watch divider; select is cleared before the filter changes
		wr(cct_pkg::OFS_PORT_ONE, 32'h0);
		wr(cct_pkg::OFS_MODE, 32'h0f);
		SRC.set_level(1'b1);
		wr(cct_pkg::OFS_PORT_THREE, 32'h1);
		wr(cct_pkg::OFS_STATUS, 32'h1);
		wr(cct_pkg::OFS_PORT_ONE, 32'h1);
		// Each quad gives one count, then one sample; the sixth sample moves the output
		repeat (6) quad();
		rd_chk(cct_pkg::OFS_STATUS, 32'h1);
		chk({31'h0, timer_irq_request}, 32'h1);
		rd_chk(cct_pkg::OFS_RISE, base + 7);
		rd_chk(cct_pkg::OFS_COUNTER, 32'h0);
		// Deselect gives a falling edge; rising edge select keeps the request away
		wr(cct_pkg::OFS_STATUS, 32'h1);
		wr(cct_pkg::OFS_PORT_ONE, 32'h0);
		repeat (6) quad();
		rd_chk(cct_pkg::OFS_STATUS, 32'h0);
		chk({31'h0, timer_irq_request}, 32'h0);
		rd_chk(cct_pkg::OFS_FALL, 32'h6);
		$display("test filter on done");
		// A frozen block ignores the watch clock entirely
		ce <= 1'b0;
		quad();
		ce <= 1'b1;
		rd_chk(cct_pkg::OFS_COUNTER, 32'h6);
		$display("test freeze done");
		report_and_stop();
	end
endmodule

// ### hdl/cct_pkg.sv
// Package with register map, field layout and timing constants of the capture timer
package cct_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_PORT_ONE = 8'h04;
	localparam logic [7:0] OFS_PORT_THREE = 8'h08;
	localparam logic [7:0] OFS_COUNTER = 8'h0c;
	localparam logic [7:0] OFS_RISE = 8'h10;
	localparam logic [7:0] OFS_FALL = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// Field positions
	localparam int POS_CLK_SEL = 0;
	localparam int POS_EDGE_SEL = 2;
	localparam int POS_CLR_LO = 3;
	localparam int POS_CLR_HI = 4;
	localparam int POS_PIN_SEL = 0;
	localparam int POS_FILT_EN = 0;
	localparam int POS_IRQ = 0;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [5:0] RST_PRESCALE = 6'h00;
	localparam logic [4:0] RST_FILTER = 5'h00;
	// Clock select codes: sys/64, sys/32, sys/2, watch/4
	localparam logic [1:0] SEL_DIV64 = 2'h0;
	localparam logic [1:0] SEL_DIV32 = 2'h1;
	localparam logic [1:0] SEL_DIV2 = 2'h2;
	localparam logic [1:0] SEL_WATCH4 = 2'h3;
	// Prescaler and watch divider bits that carry each divided clock level
	localparam int BIT_DIV64 = 5;
	localparam int BIT_DIV32 = 4;
	localparam int BIT_DIV2 = 0;
	localparam int BIT_WATCH4 = 1;
	// Noise filter depth
	localparam int FILTER_TAPS = 5;
	// Timer mode fields carried together
	typedef struct packed {
		logic clr_hi;
		logic clr_lo;
		logic edge_sel;
		logic [1:0] clk_sel;
	} cct_mode_t;
endpackage

// ### hdl/cct_timer.sv
// Capture timer: prescaler, noise filter, capture and clear logic, APB registers
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
// How it works
// - Count on falling edge of selected clock
// - High-to-low clock reselect counts once
// - Pin select toggle while high gives edge
// - Filter on, select set early: edge
// - Filter on, select cleared late: edge
// - Unselected pin gives constant low input
// - Filter enabled early after rise: rising edge
// - Filter disabled early after fall: falling edge
// - Matching spurious edge sets request flag
// - Five-tap filter updates only on agreement
// - Edges copy counter to capture registers
// - Clear selects pick clearing edges
// - Select high capture, low interval timer
module cct_timer (
	// Clock, reset and freeze
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins and status
	input wire logic capture_pin,
	input wire logic watch_clk,
	output logic timer_irq_request
);
	// Prescaler and filter state
	logic [5:0] prescale, next_prescale;
	logic [1:0] watch_div, next_watch_div;
	logic watch_prev, next_watch_prev;
	logic sel_prev, next_sel_prev;
	logic [4:0] filt_sh, next_filt_sh;
	logic filt_out, next_filt_out;
	logic filt_prev, next_filt_prev;
	// Register state
	cct_pkg::cct_mode_t timer_mode_reg, next_mode;
	logic capture_pin_select, next_pin_select;
	logic noise_filter_enable, next_filt_en;
	logic [7:0] capture_counter, next_counter;
	logic [7:0] capture_rise_reg, next_rise;
	logic [7:0] capture_fall_reg, next_fall;
	logic irq_flag, next_irq;
	logic [31:0] next_prdata;
	logic next_slverr;
	// Combinational helpers
	logic sel_lvl;
	logic inc_pulse;
	logic sample_stb;
	logic gated_in;
	logic cap_rise, cap_fall;
	logic wr_acc, rd_setup;

	// Level of the divided clock chosen by the select field
	function automatic logic clk_level(input logic [1:0] sel, input logic [5:0] pre, input logic [1:0] wd);
		case (sel)
			cct_pkg::SEL_DIV64: clk_level = pre[cct_pkg::BIT_DIV64];
			cct_pkg::SEL_DIV32: clk_level = pre[cct_pkg::BIT_DIV32];
			cct_pkg::SEL_DIV2: clk_level = pre[cct_pkg::BIT_DIV2];
			default: clk_level = wd[cct_pkg::BIT_WATCH4];
		endcase
	endfunction

	// Edge and strobe decode; the previous level is of whatever clock was selected,
	// so a reselect from high to low is indistinguishable from a real falling edge
	always_comb begin
		sel_lvl = clk_level(timer_mode_reg.clk_sel, prescale, watch_div);
		inc_pulse = sel_prev & ~sel_lvl;
		// Filter samples every cycle when off, on the selected clock's rise when on
		sample_stb = noise_filter_enable ? (~sel_prev & sel_lvl) : 1'b1;
		gated_in = capture_pin_select & capture_pin;
		cap_rise = filt_out & ~filt_prev;
		cap_fall = ~filt_out & filt_prev;
		wr_acc = psel & penable & pwrite;
		rd_setup = psel & ~penable;
	end

	// Next values of prescaler and noise filter
	always_comb begin
		next_prescale = prescale + 6'h01;
		next_watch_prev = watch_clk;
		next_watch_div = watch_div;
		// Watch clock is slow and synchronous; count its rising edges
		if (watch_clk & ~watch_prev) begin
			next_watch_div = watch_div + 2'h1;
		end
		next_sel_prev = sel_lvl;
		next_filt_sh = filt_sh;
		next_filt_out = filt_out;
		// Mode switches change the sample rate mid-run, which is where spurious edges come from
		if (sample_stb) begin
			next_filt_sh = {filt_sh[3:0], gated_in};
			// Output moves only when every tap agrees, else holds
			if (&filt_sh) begin
				next_filt_out = 1'b1;
			end else if (~|filt_sh) begin
				next_filt_out = 1'b0;
			end
		end
		next_filt_prev = filt_out;
	end

	// Register prescaler and filter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prescale <= cct_pkg::RST_PRESCALE;
			watch_div <= 2'h0;
			watch_prev <= 1'b0;
			sel_prev <= 1'b0;
			filt_sh <= cct_pkg::RST_FILTER;
			filt_out <= 1'b0;
			filt_prev <= 1'b0;
		end else if (ce) begin
			prescale <= next_prescale;
			watch_div <= next_watch_div;
			watch_prev <= next_watch_prev;
			sel_prev <= next_sel_prev;
			filt_sh <= next_filt_sh;
			filt_out <= next_filt_out;
			filt_prev <= next_filt_prev;
		end
	end

	// Next values of counter, captures, flag and bus registers
	always_comb begin
		next_mode = timer_mode_reg;
		next_pin_select = capture_pin_select;
		next_filt_en = noise_filter_enable;
		next_counter = capture_counter;
		next_rise = capture_rise_reg;
		next_fall = capture_fall_reg;
		next_irq = irq_flag;
		next_prdata = prdata;
		next_slverr = 1'b0;
		// Counting; a clearing edge in the same cycle wins
		if (inc_pulse) begin
			next_counter = capture_counter + 8'h01;
		end
		// Spurious edges travel the same path as real ones
		if (cap_rise) begin
			next_rise = capture_counter;
			if (timer_mode_reg.clr_lo) begin
				next_counter = cct_pkg::RST_BYTE;
			end
		end
		if (cap_fall) begin
			next_fall = capture_counter;
			if (timer_mode_reg.clr_hi) begin
				next_counter = cct_pkg::RST_BYTE;
			end
		end
		// Software writes, taken at the access edge
		if (wr_acc) begin
			case (paddr)
				cct_pkg::OFS_MODE: next_mode = pwdata[4:0];
				cct_pkg::OFS_PORT_ONE: next_pin_select = pwdata[cct_pkg::POS_PIN_SEL];
				cct_pkg::OFS_PORT_THREE: next_filt_en = pwdata[cct_pkg::POS_FILT_EN];
				cct_pkg::OFS_STATUS: begin
					// Write one clears the request flag
					if (pwdata[cct_pkg::POS_IRQ]) begin
						next_irq = 1'b0;
					end
				end
				default: next_mode = timer_mode_reg;
			endcase
		end
		// Setting beats a simultaneous clear
		if ((cap_rise & timer_mode_reg.edge_sel) | (cap_fall & ~timer_mode_reg.edge_sel)) begin
			next_irq = 1'b1;
		end
		// Read data is prepared in the setup cycle so pready can stand high
		if (rd_setup) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				cct_pkg::OFS_MODE: next_prdata[4:0] = timer_mode_reg;
				cct_pkg::OFS_PORT_ONE: next_prdata[cct_pkg::POS_PIN_SEL] = capture_pin_select;
				cct_pkg::OFS_PORT_THREE: next_prdata[cct_pkg::POS_FILT_EN] = noise_filter_enable;
				cct_pkg::OFS_COUNTER: next_prdata[7:0] = capture_counter;
				cct_pkg::OFS_RISE: next_prdata[7:0] = capture_rise_reg;
				cct_pkg::OFS_FALL: next_prdata[7:0] = capture_fall_reg;
				cct_pkg::OFS_STATUS: next_prdata[cct_pkg::POS_IRQ] = irq_flag;
				default: next_slverr = 1'b1;
			endcase
		end else if (psel & penable) begin
			next_slverr = pslverr;
		end
	end

	// Register counter, captures and bus state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_mode_reg <= cct_pkg::RST_BYTE[4:0];
			capture_pin_select <= 1'b0;
			noise_filter_enable <= 1'b0;
			capture_counter <= cct_pkg::RST_BYTE;
			capture_rise_reg <= cct_pkg::RST_BYTE;
			capture_fall_reg <= cct_pkg::RST_BYTE;
			irq_flag <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			timer_mode_reg <= next_mode;
			capture_pin_select <= next_pin_select;
			noise_filter_enable <= next_filt_en;
			capture_counter <= next_counter;
			capture_rise_reg <= next_rise;
			capture_fall_reg <= next_fall;
			irq_flag <= next_irq;
			prdata <= next_prdata;
			pslverr <= next_slverr;
		end
	end

	// Zero-wait slave; a frozen block cannot answer, so ready follows the enable
	assign pready = ce;
	assign timer_irq_request = irq_flag;

	// Checks
	a_count_on_fall: assert property (@(posedge clk) disable iff (rst)
		(ce && inc_pulse && !cap_rise && !cap_fall) |=>
		(capture_counter == $past(capture_counter) + 8'h01));
	// A select write that drops the level must move the counter, not just raise the pulse
	a_reselect_counts: assert property (@(posedge clk) disable iff (rst)
		(ce && $past(ce) && $changed(timer_mode_reg.clk_sel) && sel_prev && !sel_lvl
		&& !cap_rise && !cap_fall) |=> (capture_counter == $past(capture_counter) + 8'h01));
	a_unselected_low: assert property (@(posedge clk) disable iff (rst)
		(ce && !capture_pin_select && sample_stb) |=> !filt_sh[0]);
	// Selecting the pin while it is high must push a rising level through the filter
	a_select_edge: assert property (@(posedge clk) disable iff (rst)
		(ce && $rose(capture_pin_select) && capture_pin && !noise_filter_enable && !filt_out)
		##1 (ce && capture_pin && capture_pin_select && !noise_filter_enable)[*5] |=> filt_out);
	a_filter_agree: assert property (@(posedge clk) disable iff (rst)
		(ce && sample_stb && filt_sh == 5'h1f) |=> filt_out);
	a_filter_hold: assert property (@(posedge clk) disable iff (rst)
		(ce && filt_sh != 5'h1f && filt_sh != 5'h00) |=> (filt_out == $past(filt_out)));
	a_rise_capture: assert property (@(posedge clk) disable iff (rst)
		(ce && cap_rise) |=> (capture_rise_reg == $past(capture_counter)));
	a_fall_capture: assert property (@(posedge clk) disable iff (rst)
		(ce && cap_fall) |=> (capture_fall_reg == $past(capture_counter)));
	a_clear_edges: assert property (@(posedge clk) disable iff (rst)
		(ce && ((cap_rise && timer_mode_reg.clr_lo) || (cap_fall && timer_mode_reg.clr_hi)))
		|=> (capture_counter == 8'h00));
	a_irq_on_edge: assert property (@(posedge clk) disable iff (rst)
		(ce && cap_rise && timer_mode_reg.edge_sel) |=> irq_flag);
endmodule
